// File: inc/flash_protect_pkg.sv
// Shared constants and types for the flash write-protect and reset logic.
// Assumes a 200 MHz core clock and a 32 MB array of 512 blocks of 64 KB.
package flash_protect_pkg;

  // ---------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W    = 25;
  localparam int BLOCK_W   = 9;
  localparam int BLOCK_LSB = 16;
  localparam logic [BLOCK_W-1:0] BLOCK_FIRST = 9'h000;
  localparam logic [BLOCK_W-1:0] BLOCK_LAST  = 9'h1FF;
  localparam logic [BLOCK_W-1:0] BLOCK_ONE   = 9'h001;
  localparam logic [3:0] CODE_NONE     = 4'h0;
  localparam logic [3:0] CODE_LAST_LOG = 4'h9;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS    = 5000;
  localparam int RESET_LOW_MIN_NS   = 1;
  localparam int RESET_LOW_MIN_NS_X = RESET_LOW_MIN_NS * 1000;
  // Least time, so rounded up to whole cycles.
  localparam int RESET_LOW_MIN_CYCLES =
    (RESET_LOW_MIN_NS_X * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int RST_CNT_W = $clog2(RESET_LOW_MIN_CYCLES + 1);
  localparam logic [RST_CNT_W-1:0] RESET_FIRE_COUNT =
    RST_CNT_W'(RESET_LOW_MIN_CYCLES - 1);

  // ---------------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------------
  localparam int POS_WEL      = 1;
  localparam int POS_RANGE    = 2;
  localparam int POS_LOCK_LO  = 7;
  localparam int POS_LOCK_HI  = 8;
  localparam int POS_QUAD     = 9;
  localparam int POS_INVERT   = 14;
  localparam int POS_PIN_FUNC = 23;
  localparam int STATUS_W     = 24;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACTIVE   = 2'b00,
    ST_DEEP_PD  = 2'b01,
    ST_HW_RESET = 2'b10
  } mode_t;

  typedef struct packed {
    logic       pin_function_sel;
    logic       protect_invert_bit;
    logic       quad_io_enable;
    logic       status_lock_bit_hi;
    logic       status_lock_bit_lo;
    logic [4:0] protect_range_bits;
  } status_bits_t;

  typedef struct packed {
    logic set_write_latch_cmd;
    logic clear_write_latch_cmd;
    logic status_write_cmd;
    logic page_program_cmd;
    logic sector_erase_cmd;
    logic block_erase_cmd;
    logic chip_erase_cmd;
    logic reset_enable_cmd;
    logic reset_do_cmd;
    logic power_down_cmd;
    logic power_release_cmd;
  } cmd_t;

  typedef struct packed {
    logic               none;
    logic [BLOCK_W-1:0] lo;
    logic [BLOCK_W-1:0] hi;
  } prot_range_t;

  localparam status_bits_t NV_RESET = '0;

  typedef struct packed {
    mode_t                mode;
    logic [1:0]           rst_sync;
    logic [1:0]           wp_sync;
    logic [RST_CNT_W-1:0] low_count;
    logic                 reset_armed;
    logic                 write_enable_latch;
    status_bits_t         nv;
    logic                 op_done;
    logic                 op_reject;
    logic                 sr_reject;
    logic                 hw_reset_pulse;
    logic [STATUS_W-1:0]  status_word;
  } core_state_t;

endpackage

// File: src/protect_range_decoder.sv
// Decodes protect bits and the invert bit into a protected block range.
// Purely combinational; the caller samples it on its own clock.
`timescale 1ns/1ps
`default_nettype none

module protect_range_decoder
  import flash_protect_pkg::*;
(
  input  wire logic [4:0] protect_range_bits,
  input  wire logic       protect_invert_bit,
  output prot_range_t     range
);

  // -----------------------------------------------------------------------
  // Range decode
  // -----------------------------------------------------------------------
  logic [3:0]         code;
  logic [BLOCK_W-1:0] span;
  logic               p_none;
  logic               p_all;
  logic [BLOCK_W-1:0] p_lo;
  logic [BLOCK_W-1:0] p_hi;

  // Plain ranges first; the invert bit then takes the complement, which
  // always stays one contiguous run because plain ranges touch an end.
  always_comb begin
    code   = protect_range_bits[3:0];
    span   = BLOCK_ONE << (code - 4'h1);
    p_none = 1'b0;
    p_all  = 1'b0;
    p_lo   = BLOCK_FIRST;
    p_hi   = BLOCK_LAST;
    if (code == CODE_NONE) begin
      p_none = 1'b1;
    end else if (code > CODE_LAST_LOG) begin
      p_all = 1'b1;
    end else if (!protect_range_bits[4]) begin
      p_lo = BLOCK_FIRST - span;
    end else begin
      p_hi = span - BLOCK_ONE;
    end
    range.none = p_none;
    range.lo   = p_lo;
    range.hi   = p_hi;
    if (protect_invert_bit) begin
      if (p_none) begin
        range.none = 1'b0;
      end else if (p_all) begin
        range.none = 1'b1;
      end else if (!protect_range_bits[4]) begin
        range.lo = BLOCK_FIRST;
        range.hi = p_lo - BLOCK_ONE;
      end else begin
        range.lo = p_hi + BLOCK_ONE;
        range.hi = BLOCK_LAST;
      end
    end
  end

endmodule

`default_nettype wire

// File: src/flash_write_protect_and_reset.sv
// Write-enable latch, protection modes, range check and pin reset of a
// serial NOR flash. Commands arrive as decoded one-cycle pulses from the
// command front end on the same clock; the pins arrive asynchronously.
//
// Notes on behaviour
// - Function select high makes shared pin a reset.
// - Pin reset honoured only while quad enable low.
// - Pin low at least 1 us resets device.
// - After reset: standby, volatile bits at power-on values.
// - Set-latch command sets write enable latch.
// - Listed commands and resets clear write enable latch.
// - Protected region stays readable, never modified.
// - Hardware mode, protect pin low freezes protect bits.
// - Deep power-down ignores all but release, reset.
// - Plain code protects top blocks, or none/all.
// - Plain code with bit 4 protects bottom blocks.
// - Inverted code protects all but top blocks.
// - Inverted code with bit 4 spares bottom blocks.
// - Chip erase only when nothing is protected.
// - Hardware lock with protect pin low rejects status writes.
// - Function select is status bit 23, non-volatile.
`timescale 1ns/1ps
`default_nettype none

module flash_write_protect_and_reset
  import flash_protect_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                reset_pin_n,
  input  wire logic                write_protect_pin_n,
  input  wire cmd_t                cmd,
  input  wire status_bits_t        status_data,
  input  wire logic [ADDR_W-1:0]   target_addr,
  output logic                     write_enable_latch,
  output status_bits_t             nv_status,
  output logic                     deep_power_down,
  output logic                     in_hw_reset,
  output logic                     hw_reset_done,
  output logic                     op_done,
  output logic                     op_reject,
  output logic                     status_write_reject,
  output logic [STATUS_W-1:0]      status_word
);

  // -----------------------------------------------------------------------
  // Protection range
  // -----------------------------------------------------------------------
  core_state_t state_reg;
  core_state_t state_next;
  prot_range_t range;

  protect_range_decoder u_decoder (
    .protect_range_bits (state_reg.nv.protect_range_bits),
    .protect_invert_bit (state_reg.nv.protect_invert_bit),
    .range              (range)
  );

  // -----------------------------------------------------------------------
  // Derived conditions
  // -----------------------------------------------------------------------
  logic [BLOCK_W-1:0] target_block;
  logic               in_range;
  logic               reset_role;
  logic               pin_low;
  logic               wp_low;
  logic               sr_locked;
  logic               active;
  logic               array_cmd;

  // The range check works per 64 KB block, which is also the finest grain
  // the protect codes can express.
  assign target_block = target_addr[ADDR_W-1:BLOCK_LSB];
  assign in_range     = !range.none && (target_block >= range.lo) &&
                        (target_block <= range.hi);
  assign reset_role   = state_reg.nv.pin_function_sel &&
                        !state_reg.nv.quad_io_enable;
  assign pin_low      = reset_role && !state_reg.rst_sync[1];
  assign wp_low       = !state_reg.wp_sync[1];
  assign sr_locked    = state_reg.nv.status_lock_bit_hi ||
                        (state_reg.nv.status_lock_bit_lo && wp_low);
  assign active       = (state_reg.mode == ST_ACTIVE) && !pin_low;
  assign array_cmd    = cmd.page_program_cmd || cmd.sector_erase_cmd ||
                        cmd.block_erase_cmd;

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  // One command per cycle is expected; the if chain fixes priority anyway.
  always_comb begin
    state_next                = state_reg;
    state_next.op_done        = 1'b0;
    state_next.op_reject      = 1'b0;
    state_next.sr_reject      = 1'b0;
    state_next.hw_reset_pulse = 1'b0;
    state_next.rst_sync = {state_reg.rst_sync[0], reset_pin_n};
    state_next.wp_sync  = {state_reg.wp_sync[0], write_protect_pin_n};
    if (!pin_low) begin
      state_next.low_count = '0;
    end else if (state_reg.low_count != RESET_FIRE_COUNT) begin
      state_next.low_count = state_reg.low_count + 1'b1;
    end
    case (state_reg.mode)
      ST_HW_RESET: begin
        // Stay in reset while the pin is held, then fall back to standby.
        if (!pin_low) begin
          state_next.mode = ST_ACTIVE;
        end
      end
      default: begin
        if (pin_low && state_reg.low_count == RESET_FIRE_COUNT) begin
          state_next.mode                  = ST_HW_RESET;
          state_next.hw_reset_pulse        = 1'b1;
          state_next.write_enable_latch    = 1'b0;
          state_next.reset_armed           = 1'b0;
          state_next.nv.status_lock_bit_hi = 1'b0;
        end else if (!pin_low && (|cmd)) begin
          state_next.reset_armed = cmd.reset_enable_cmd;
          if (cmd.reset_do_cmd && state_reg.reset_armed) begin
            state_next.mode                  = ST_ACTIVE;
            state_next.write_enable_latch    = 1'b0;
            state_next.nv.status_lock_bit_hi = 1'b0;
          end else if (state_reg.mode == ST_DEEP_PD) begin
            if (cmd.power_release_cmd) begin
              state_next.mode = ST_ACTIVE;
            end
          end else if (cmd.power_down_cmd) begin
            state_next.mode = ST_DEEP_PD;
          end else if (cmd.set_write_latch_cmd) begin
            state_next.write_enable_latch = 1'b1;
          end else if (cmd.clear_write_latch_cmd) begin
            state_next.write_enable_latch = 1'b0;
          end else if (cmd.status_write_cmd) begin
            state_next.write_enable_latch = 1'b0;
            if (state_reg.write_enable_latch && !sr_locked) begin
              state_next.nv      = status_data;
              state_next.op_done = 1'b1;
            end else begin
              state_next.op_reject = 1'b1;
              state_next.sr_reject = 1'b1;
            end
          end else if (array_cmd) begin
            state_next.write_enable_latch = 1'b0;
            if (state_reg.write_enable_latch && !in_range) begin
              state_next.op_done = 1'b1;
            end else begin
              state_next.op_reject = 1'b1;
            end
          end else if (cmd.chip_erase_cmd) begin
            state_next.write_enable_latch = 1'b0;
            if (state_reg.write_enable_latch && range.none) begin
              state_next.op_done = 1'b1;
            end else begin
              state_next.op_reject = 1'b1;
            end
          end
        end
      end
    endcase
    // Status image mirrors the next state so it is valid with the outputs.
    state_next.status_word                 = '0;
    state_next.status_word[POS_WEL]        = state_next.write_enable_latch;
    state_next.status_word[POS_RANGE+:5]   =
      state_next.nv.protect_range_bits;
    state_next.status_word[POS_LOCK_LO]    = state_next.nv.status_lock_bit_lo;
    state_next.status_word[POS_LOCK_HI]    = state_next.nv.status_lock_bit_hi;
    state_next.status_word[POS_QUAD]       = state_next.nv.quad_io_enable;
    state_next.status_word[POS_INVERT]     = state_next.nv.protect_invert_bit;
    state_next.status_word[POS_PIN_FUNC]   =
      state_next.nv.pin_function_sel;
  end

  // -----------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------
  // Pin synchronisers idle high so a reset never starts from power-on.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg          <= '0;
      state_reg.mode     <= ST_ACTIVE;
      state_reg.rst_sync <= 2'b11;
      state_reg.wp_sync  <= 2'b11;
      state_reg.nv       <= NV_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register. The mode codes give
  // deep power-down and pin reset one bit each, so no gate follows them.
  assign write_enable_latch  = state_reg.write_enable_latch;
  assign nv_status           = state_reg.nv;
  assign deep_power_down     = state_reg.mode[0];
  assign in_hw_reset         = state_reg.mode[1];
  assign hw_reset_done       = state_reg.hw_reset_pulse;
  assign op_done             = state_reg.op_done;
  assign op_reject           = state_reg.op_reject;
  assign status_write_reject = state_reg.sr_reject;
  assign status_word         = state_reg.status_word;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_RESET_AFTER_MIN_LOW: assert property (
    $rose(state_reg.hw_reset_pulse) |->
      $past(state_reg.low_count) == RESET_FIRE_COUNT && $past(pin_low))
    else $error("Pin reset fired before the minimum low time.");

  AST_NO_RESET_IN_QUAD: assert property (
    state_reg.nv.quad_io_enable |=> !state_reg.hw_reset_pulse)
    else $error("Pin reset taken while quad enable set.");

  AST_NO_RESET_AS_HOLD: assert property (
    !state_reg.nv.pin_function_sel |=> !state_reg.hw_reset_pulse)
    else $error("Pin reset taken while pin has hold role.");

  AST_RESET_DEFAULTS: assert property (
    state_reg.hw_reset_pulse |-> !state_reg.write_enable_latch &&
      !state_reg.reset_armed && !state_reg.nv.status_lock_bit_hi &&
      state_reg.mode == ST_HW_RESET)
    else $error("Volatile state not at defaults after pin reset.");

  AST_SET_LATCH: assert property (
    active && cmd == cmd_t'{set_write_latch_cmd: 1'b1, default: 1'b0} |=>
      state_reg.write_enable_latch)
    else $error("Set-latch command did not set the latch.");

  AST_CLEAR_LATCH: assert property (
    active && (array_cmd || cmd.chip_erase_cmd || cmd.status_write_cmd ||
      cmd.clear_write_latch_cmd) |=> !state_reg.write_enable_latch)
    else $error("Write enable latch survived a clearing command.");

  AST_PROTECTED_REJECT: assert property (
    active && cmd == cmd_t'{page_program_cmd: 1'b1, default: 1'b0} &&
      in_range |=> state_reg.op_reject && !state_reg.op_done)
    else $error("Program inside protected range was not rejected.");

  AST_CHIP_ERASE_GUARD: assert property (
    active && cmd == cmd_t'{chip_erase_cmd: 1'b1, default: 1'b0} &&
      !range.none |=> state_reg.op_reject)
    else $error("Chip erase ran with a protected region.");

  AST_HW_LOCK: assert property (
    active && cmd == cmd_t'{status_write_cmd: 1'b1, default: 1'b0} &&
      state_reg.nv.status_lock_bit_lo && wp_low
      |=> $stable(state_reg.nv) && state_reg.sr_reject)
    else $error("Status write accepted under hardware lock.");

  AST_DEEP_PD_IGNORE: assert property (
    state_reg.mode == ST_DEEP_PD && !pin_low && !cmd.reset_do_cmd
      |=> $stable(state_reg.write_enable_latch) && $stable(state_reg.nv))
    else $error("Command acted during deep power-down.");

  AST_DECODE_NONE: assert property (
    state_reg.nv.protect_range_bits[3:0] == CODE_NONE &&
      !state_reg.nv.protect_invert_bit |-> range.none)
    else $error("Code zero did not decode to no protection.");

  AST_DECODE_INVERT: assert property (
    state_reg.nv.protect_range_bits == 5'h01 &&
      state_reg.nv.protect_invert_bit |->
      !range.none && range.lo == 9'h000 && range.hi == 9'h1FE)
    else $error("Inverted code one did not spare the top block.");

  COV_PIN_RESET: cover property (state_reg.hw_reset_pulse);
  COV_REJECT_PROGRAM: cover property (
    state_reg.op_reject && !state_reg.sr_reject);
  COV_STATUS_WRITE_OK: cover property (
    state_reg.op_done ##1 state_reg.nv.pin_function_sel);
  COV_DEEP_PD_EXIT: cover property (
    state_reg.mode == ST_DEEP_PD ##1 state_reg.mode == ST_ACTIVE);

endmodule

`default_nettype wire

// File: tb/flash_host_model.sv
// Host-side pin driver: the shared reset pin and the write-protect pin.
// Assumes its tasks are called from the bench thread on a falling edge.
`timescale 1ns/1ps
`default_nettype none

module flash_host_model (
  input  wire logic clock,
  output var  logic reset_pin_n,
  output var  logic write_protect_pin_n
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Both pins rest high, as their pull-ups leave them when released.
  initial begin
    reset_pin_n         = 1'b1;
    write_protect_pin_n = 1'b1;
  end

  // Holds reset low for a chosen count; short holds break the minimum.
  task automatic hold_reset(input int cycles);
    @(negedge clock);
    reset_pin_n = 1'b0;
    repeat (cycles) @(negedge clock);
    reset_pin_n = 1'b1;
    repeat (4) @(negedge clock); // Covers the pin synchroniser delay.
  endtask

  // Moves the protect pin, then waits out its synchroniser.
  task automatic set_wp(input logic level);
    @(negedge clock);
    write_protect_pin_n = level;
    repeat (3) @(negedge clock);
  endtask
endmodule

`default_nettype wire

// File: tb/flash_write_protect_and_reset_tb.sv
// Self-checking bench for the flash write-protect and reset block.
// Assumes the package constants and the host pin model beside it.
`timescale 1ns/1ps
`default_nettype none

module flash_write_protect_and_reset_tb;
  import flash_protect_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int C_SET = 10, C_CLR = 9, C_WSR = 8, C_PP = 7, C_CE = 4;
  localparam int C_REN = 3, C_RDO = 2, C_PD = 1, C_REL = 0;
  logic                clock = 1'b0;
  logic                reset_n;
  logic                reset_pin_n;
  logic                write_protect_pin_n;
  cmd_t                cmd;
  status_bits_t        status_data;
  status_bits_t        nv_status;
  status_bits_t        d;
  logic [ADDR_W-1:0]   target_addr;
  logic                write_enable_latch;
  logic                deep_power_down;
  logic                in_hw_reset;
  logic                hw_reset_done;
  logic                op_done;
  logic                op_reject;
  logic                status_write_reject;
  logic [STATUS_W-1:0] status_word;
  int                  n_mismatch = 0;
  int                  total_checks = 0;
  int                  n_fire = 0;
  int                  k = 0;

  flash_write_protect_and_reset u_flash_write_protect_and_reset (
    .clock(clock), .reset_n(reset_n), .reset_pin_n(reset_pin_n),
    .write_protect_pin_n(write_protect_pin_n), .cmd(cmd),
    .status_data(status_data), .target_addr(target_addr),
    .write_enable_latch(write_enable_latch), .nv_status(nv_status),
    .deep_power_down(deep_power_down), .in_hw_reset(in_hw_reset),
    .hw_reset_done(hw_reset_done), .op_done(op_done),
    .op_reject(op_reject), .status_write_reject(status_write_reject),
    .status_word(status_word));

  flash_host_model u_flash_host_model (
    .clock(clock), .reset_pin_n(reset_pin_n),
    .write_protect_pin_n(write_protect_pin_n));

  // ----------------------------------------------------------------
  // Clock, reset-pulse monitor and hang guard
  // ----------------------------------------------------------------
  // A 5 ns clock; the monitor counts pin resets so misfires show up.
  always #2.5 clock = ~clock;

  // Sampled mid-cycle, where the one-cycle pulse has settled.
  always @(negedge clock) begin
    if (hw_reset_done === 1'b1) n_fire++;
  end

  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command pulse; returns in the cycle that shows its answer.
  task automatic send(input int pos);
    cmd_t c;
    c = '0;
    c[pos] = 1'b1;
    @(negedge clock);
    cmd = c;
    @(negedge clock);
    cmd = '0;
  endtask

  task automatic op(input int pos, input logic ok);
    send(pos);
    chk(op_done, ok);
    chk(op_reject, !ok);
    chk(write_enable_latch, 1'b0);
  endtask

  task automatic wsr(input status_bits_t v, input logic ok);
    send(C_SET);
    status_data = v;
    op(C_WSR, ok);
  endtask

  // Sets a protection code, then programs or erases one block; the
  // command kind rotates so all three array commands see the check, and
  // the offset inside the block swings between its two ends.
  task automatic prot(input logic inv, input logic [4:0] rng,
                      input logic [8:0] blk, input logic rej);
    status_bits_t v;
    v = '0;
    v.protect_invert_bit = inv;
    v.protect_range_bits = rng;
    wsr(v, 1'b1);
    target_addr = {blk, k[0] ? 16'hFFFF : 16'h0000};
    send(C_SET);
    op(C_PP - k % 3, !rej);
    k++;
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 50 && in_hw_reset !== 1'b0; i++) @(negedge clock);
    if (i == 50) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cmd = '0;
    status_data = '0;
    target_addr = '0;
    reset_n = 1'b0;
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    chk(status_word, 0);
    send(C_SET);
    chk(write_enable_latch, 1);
    chk(status_word[POS_WEL], 1);
    send(C_CLR);
    chk(write_enable_latch, 0);
    op(C_WSR, 1'b0);
    op(C_PP, 1'b0);
    // Hold/reset pin still in hold role: a long low must not reset.
    send(C_SET);
    u_flash_host_model.hold_reset(202);
    chk(n_fire, 0);
    chk(write_enable_latch, 1);
    // Decoder corners across every range family.
    prot(0, 5'h00, 9'h1FF, 0);
    prot(0, 5'h10, 9'h000, 0);
    prot(0, 5'h01, 9'h1FF, 1);
    prot(0, 5'h01, 9'h1FE, 0);
    prot(0, 5'h09, 9'h100, 1);
    prot(0, 5'h09, 9'h0FF, 0);
    prot(0, 5'h0C, 9'h000, 1);
    prot(0, 5'h0A, 9'h000, 1);
    prot(0, 5'h11, 9'h000, 1);
    prot(0, 5'h11, 9'h001, 0);
    prot(0, 5'h19, 9'h0FF, 1);
    prot(0, 5'h19, 9'h100, 0);
    prot(1, 5'h00, 9'h1FF, 1);
    prot(1, 5'h01, 9'h1FE, 1);
    prot(1, 5'h01, 9'h1FF, 0);
    prot(1, 5'h09, 9'h100, 0);
    prot(1, 5'h09, 9'h0FF, 1);
    prot(1, 5'h11, 9'h000, 0);
    prot(1, 5'h11, 9'h001, 1);
    prot(1, 5'h0C, 9'h1FF, 0);
    prot(1, 5'h0A, 9'h000, 0);
    chk(status_word, 24'h004028);
    send(C_SET);
    op(C_CE, 1'b1);
    prot(0, 5'h01, 9'h000, 0);
    send(C_SET);
    op(C_CE, 1'b0);
    // Hardware protection: lock low bit with the protect pin low.
    d = '0;
    d.status_lock_bit_lo = 1'b1;
    wsr(d, 1'b1);
    chk(status_word, 24'h000080);
    u_flash_host_model.set_wp(1'b0);
    wsr(10'h01F, 1'b0);
    chk(status_write_reject, 1);
    chk(nv_status, d);
    u_flash_host_model.set_wp(1'b1);
    wsr('0, 1'b1);
    // Deep power-down passes only release and the reset pair.
    send(C_PD);
    chk(deep_power_down, 1);
    send(C_SET);
    chk(write_enable_latch, 0);
    send(C_REL);
    chk(deep_power_down, 0);
    send(C_SET);
    send(C_PD);
    send(C_REN);
    send(C_RDO);
    chk(deep_power_down, 0);
    chk(write_enable_latch, 0);
    // Pin in reset role: short hold ignored, full hold resets.
    d = '0;
    d.pin_function_sel = 1'b1;
    d.status_lock_bit_hi = 1'b1;
    wsr(d, 1'b1);
    chk(status_word[POS_PIN_FUNC], 1);
    send(C_SET);
    u_flash_host_model.hold_reset(198);
    chk(n_fire, 0);
    u_flash_host_model.hold_reset(202);
    chk(n_fire, 1);
    wait_idle();
    chk(write_enable_latch, 0);
    chk(deep_power_down, 0);
    chk(nv_status.status_lock_bit_hi, 0);
    chk(nv_status.pin_function_sel, 1);
    // Quad enable turns the pin into data: no reset at all.
    d.status_lock_bit_hi = 1'b0;
    d.quad_io_enable = 1'b1;
    wsr(d, 1'b1);
    chk(status_word, 24'h800200);
    send(C_SET);
    u_flash_host_model.hold_reset(250);
    chk(n_fire, 1);
    chk(write_enable_latch, 1);
    // Power-on reset in mid-run returns every bit to its default.
    @(negedge clock);
    reset_n = 1'b0;
    @(negedge clock);
    chk(status_word, 0);
    chk(nv_status, 0);
    chk(write_enable_latch, 0);
    reset_n = 1'b1;
    send(C_SET);
    chk(write_enable_latch, 1);
    tally_and_finish();
  end
endmodule

`default_nettype wire
